// ===== mac_link_model.sv
module mac_link_model
  import mac_status_pkg::*;
(
  // Clock
  input wire logic clk,
  // Network side
  output tx_report_t tx_report,
  output logic pause_rx,
  output logic [15:0] pause_quanta,
  output rx_frame_t rx_frame,
  output logic full_duplex
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle lines at start
  initial begin
    tx_report = '0;
    pause_rx = 1'b0;
    pause_quanta = '0;
    rx_frame = '0;
    full_duplex = 1'b0;
  end

  task tx_end(input logic u, l, m, input logic [5:0] id);
    @(posedge clk) tx_report <= {1'b1, u, l, m, id};
    @(posedge clk) tx_report <= {1'b0, ~u, ~l, ~m, ~id};
  endtask

  // Frame start pulse
  task rx_start;
    @(posedge clk) rx_frame.start <= 1'b1;
    @(posedge clk) rx_frame.start <= 1'b0;
  endtask

  // Frame end, fields scrambled after
  task rx_end(input logic [47:0] da, input logic ce, hh);
    @(posedge clk) rx_frame <= {2'b01, ce, hh, da};
    @(posedge clk) rx_frame <= {2'b00, ~ce, ~hh, ~da};
  endtask

  task pause(input logic fd, input logic [15:0] q);
    @(posedge clk);
    full_duplex <= fd;
    pause_rx <= 1'b1;
    pause_quanta <= q;
    @(posedge clk);
    pause_rx <= 1'b0;
    pause_quanta <= ~q;
  endtask
endmodule

// ===== mac_status_ctrl.sv
// Functional notes
// - Underrun sets transmit status bit 14.
// - Underrun is fatal; transmit stays halted until reset or restart.
// - Late collision sets transmit status bit 13.
// - Reaching maximum collisions sets transmit status bit 12.
// - Bits 5..0 hold frame id; all flags describe that frame.
// - Transmit status shows only the latest frame, replacing older status.
// - Bit 10 in full duplex: received pause holds transmit until timer expires.
// - Bit 9 keeps CRC-error frames; cleared, they are discarded.
// - Bit 7 accepts all broadcast frames.
// - Bit 6 accepts all multicast frames, broadcast included.
// - Bit 5 accepts unicast frames matching the 48-bit station address.
// - Bit 4 accepts every frame regardless of destination.
// - Bit 3 strips CRC; cleared, CRC is stored after the packet.
// - Bit 2 accepts multicast frames passing the hash filter.
// - Bit 0 runs receiver; clearing stops after the current frame.
//
// Design decision made here: the Avalon-MM interface to the registers.
module mac_status_ctrl
  import mac_status_pkg::*;
#(
  parameter int PAUSE_QUANTUM = PAUSE_QUANTUM_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Avalon-MM slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Transmit side
  input wire tx_report_t tx_report,
  input wire logic tx_restart,
  output logic tx_halt,
  output logic tx_hold,
  // Pause frames and duplex
  input wire logic full_duplex,
  input wire logic pause_rx,
  input wire logic [15:0] pause_quanta,
  // Receive side
  input wire rx_frame_t rx_frame,
  input wire logic [47:0] station_addr,
  output rx_verdict_t rx_verdict,
  output logic rx_running,
  // Interrupt
  output logic irq
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [15:0] txs_r;
  logic [15:0] rxc_r;
  logic [EV_W-1:0] ev_status_r;
  logic [EV_W-1:0] ev_mask_r;
  logic halt_r;
  logic [15:0] pause_left_r;
  logic [15:0] quantum_cnt_r;
  rx_state_t rx_state_r;
  rx_state_t rx_state_nxt;
  rx_verdict_t verdict_r;
  logic ack_r;
  logic [31:0] rdata_r;
  logic irq_r;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic [3:0] idx;
  logic req;
  logic wr_take;
  logic lo_lane;
  logic hi_lane;
  logic [15:0] wmask;

  assign idx = avs_address[5:2];
  assign req = avs_read | avs_write;
  assign wr_take = avs_write & ack_r;
  assign lo_lane = avs_byteenable[0];
  assign hi_lane = avs_byteenable[1];
  assign wmask = {{8{hi_lane}}, {8{lo_lane}}};

  // One wait state, then accept at the edge where waitrequest is low
  always_ff @(posedge clk) begin
    if (srst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // Read data staged alongside the acknowledge
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_r <= 32'h0000_0000;
    end else if (avs_read & ~ack_r) begin
      case (idx)
        IDX_TRANSMIT_STATUS: rdata_r <= {16'h0000, txs_r};
        IDX_RECEIVE_CONTROL: rdata_r <= {16'h0000, rxc_r};
        IDX_EVENT_STATUS: rdata_r <= {28'h0000000, ev_status_r};
        IDX_EVENT_MASK: rdata_r <= {28'h0000000, ev_mask_r};
        IDX_LINK_STATE: begin
          rdata_r <= {29'h00000000, (pause_left_r != 16'h0000), halt_r,
                      (rx_state_r != RX_STOPPED)};
        end
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Transmit status
  // ----------------------------------------
  // Whole register replaced at frame end
  // atomic status update
  always_ff @(posedge clk) begin
    if (srst) begin
      txs_r <= TXS_RESET;
    end else if (tx_report.done) begin
      txs_r <= 16'h0000;
      txs_r[TXS_UNDERRUN_BIT] <= tx_report.underrun;
      txs_r[TXS_LATE_COL_BIT] <= tx_report.late_collision;
      txs_r[TXS_MAX_COL_BIT] <= tx_report.max_collision;
      txs_r[TXS_FID_LSB +: FID_W] <= tx_report.frame_id;
    end
  end

  // Fatal underrun latch; restart or reset recovers
  // underrun halts transmit
  // underrun stems from a slow host
  always_ff @(posedge clk) begin
    if (srst) begin
      halt_r <= 1'b0;
    end else if (tx_report.done & tx_report.underrun) begin
      halt_r <= 1'b1;
    end else if (tx_restart) begin
      halt_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Pause timer
  // ----------------------------------------
  logic quantum_tick;
  logic pause_honoured;

  assign quantum_tick = (quantum_cnt_r == 16'(PAUSE_QUANTUM - 1));
  assign pause_honoured = rxc_r[RXC_PAUSE_BIT] & full_duplex;

  // Quantum divider, restarted by each pause frame honoured (bit 10 set, full duplex)
  always_ff @(posedge clk) begin
    if (srst) begin
      quantum_cnt_r <= 16'h0000;
    end else if ((pause_rx & pause_honoured) | quantum_tick) begin
      quantum_cnt_r <= 16'h0000;
    end else if (pause_left_r != 16'h0000) begin
      quantum_cnt_r <= quantum_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pause_left_r <= 16'h0000;
    end else if (pause_rx & pause_honoured) begin
      pause_left_r <= pause_quanta;
    end else if (!pause_honoured) begin
      pause_left_r <= 16'h0000;
    end else if (quantum_tick & (pause_left_r != 16'h0000)) begin
      pause_left_r <= pause_left_r - 16'h0001;
    end
  end

  // ----------------------------------------
  // Receive control register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      rxc_r <= RXC_RESET;
    end else if (wr_take & (idx == IDX_RECEIVE_CONTROL)) begin
      rxc_r <= (rxc_r & ~(wmask & RXC_WRITABLE)) |
               (avs_writedata[15:0] & wmask & RXC_WRITABLE);
    end
  end

  // ----------------------------------------
  // Receiver run state
  // ----------------------------------------
  // stop waits for frame end
  always_comb begin
    rx_state_nxt = rx_state_r;
    case (rx_state_r)
      RX_STOPPED: begin
        if (rxc_r[RXC_RUN_BIT]) begin
          rx_state_nxt = RX_IDLE;
        end
      end
      RX_IDLE: begin
        if (!rxc_r[RXC_RUN_BIT]) begin
          rx_state_nxt = RX_STOPPED;
        end else if (rx_frame.start) begin
          rx_state_nxt = RX_BUSY;
        end
      end
      RX_BUSY: begin
        if (rx_frame.done) begin
          rx_state_nxt = rxc_r[RXC_RUN_BIT] ? RX_IDLE : RX_STOPPED;
        end
      end
      default: rx_state_nxt = RX_STOPPED;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_state_r <= RX_STOPPED;
    end else begin
      rx_state_r <= rx_state_nxt;
    end
  end

  // ----------------------------------------
  // Address filter
  // ----------------------------------------
  logic is_bcast;
  logic is_mcast;
  logic is_ucast_hit;
  logic addr_ok;
  logic crc_ok;

  assign is_bcast = (rx_frame.dest_addr == BCAST_ADDR);
  assign is_mcast = rx_frame.dest_addr[40];
  assign is_ucast_hit = ~is_mcast & (rx_frame.dest_addr == station_addr);

  always_comb begin
    addr_ok = 1'b0;
    if (rxc_r[RXC_ALL_BIT]) begin
      addr_ok = 1'b1;
    end
    if (rxc_r[RXC_BCAST_BIT] & is_bcast) begin
      addr_ok = 1'b1;
    end
    if (rxc_r[RXC_MCAST_BIT] & is_mcast) begin
      addr_ok = 1'b1;
    end
    if (rxc_r[RXC_UCAST_BIT] & is_ucast_hit) begin
      addr_ok = 1'b1;
    end
    if (rxc_r[RXC_HASH_BIT] & is_mcast & rx_frame.hash_hit) begin
      addr_ok = 1'b1;
    end
  end

  assign crc_ok = ~rx_frame.crc_error | rxc_r[RXC_ERR_FRAME_BIT];

  // Verdict pulse at end of each frame taken while running
  always_ff @(posedge clk) begin
    if (srst) begin
      verdict_r <= '0;
    end else begin
      verdict_r.keep <= (rx_state_r == RX_BUSY) & rx_frame.done & addr_ok & crc_ok;
      verdict_r.drop <= (rx_state_r == RX_BUSY) & rx_frame.done & ~(addr_ok & crc_ok);
      verdict_r.strip_crc <= rxc_r[RXC_STRIP_BIT];
    end
  end

  // ----------------------------------------
  // Events and interrupt
  // ----------------------------------------
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;

  always_comb begin
    ev_set = '0;
    ev_set[EV_TX_DONE_BIT] = tx_report.done;
    ev_set[EV_TX_UNDERRUN_BIT] = tx_report.done & tx_report.underrun;
    ev_set[EV_RX_KEPT_BIT] = verdict_r.keep;
    ev_set[EV_RX_DROPPED_BIT] = verdict_r.drop;
  end

  assign ev_clr = (wr_take & (idx == IDX_EVENT_STATUS) & lo_lane) ?
                  avs_writedata[EV_W-1:0] : '0;

  // Sticky bits, set wins over write-one clear
  always_ff @(posedge clk) begin
    if (srst) begin
      ev_status_r <= EV_RESET;
    end else begin
      ev_status_r <= (ev_status_r & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ev_mask_r <= EV_RESET;
    end else if (wr_take & (idx == IDX_EVENT_MASK) & lo_lane) begin
      ev_mask_r <= avs_writedata[EV_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(((ev_status_r & ~ev_clr) | ev_set) & ev_mask_r);
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  logic run_out_r;
  logic hold_out_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      run_out_r <= 1'b0;
      hold_out_r <= 1'b0;
    end else begin
      run_out_r <= (rx_state_nxt != RX_STOPPED);
      hold_out_r <= ((pause_rx & pause_honoured) & (pause_quanta != 16'h0000)) |
                    (pause_honoured & ~(quantum_tick & (pause_left_r == 16'h0001)) &
                     (pause_left_r != 16'h0000) & ~(pause_rx & pause_honoured));
    end
  end

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = ~ack_r;
  assign tx_halt = halt_r;
  assign tx_hold = hold_out_r;
  assign rx_verdict = verdict_r;
  assign rx_running = run_out_r;
  assign irq = irq_r;

endmodule

// ===== mac_status_ctrl_checker.sv
module mac_status_ctrl_checker
  import mac_status_pkg::*;
#(
  parameter int PAUSE_QUANTUM = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Transmit and pause
  input wire tx_report_t tx_report,
  input wire logic tx_restart,
  input wire logic tx_halt,
  input wire logic tx_hold,
  input wire logic full_duplex,
  input wire logic pause_rx,
  // Receive
  input wire rx_frame_t rx_frame,
  input wire rx_verdict_t rx_verdict
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  chk_underrun_halt: assert property (
    tx_report.done && tx_report.underrun |=> tx_halt)
    else $error("halt missing after underrun");
  chk_halt_cause: assert property (
    $rose(tx_halt) |-> $past(tx_report.done && tx_report.underrun))
    else $error("halt without underrun");
  chk_halt_sticky: assert property (
    tx_halt && !tx_restart |=> tx_halt)
    else $error("halt dropped without restart");
  chk_restart_clears: assert property (
    tx_restart && !(tx_report.done && tx_report.underrun) |=> !tx_halt)
    else $error("halt kept after restart");
  chk_verdict_excl: assert property (
    !(rx_verdict.keep && rx_verdict.drop))
    else $error("keep and drop together");
  chk_verdict_cause: assert property (
    rx_verdict.keep || rx_verdict.drop |-> $past(rx_frame.done))
    else $error("verdict without frame end");
  chk_verdict_pulse: assert property (
    rx_verdict.keep || rx_verdict.drop |=> !(rx_verdict.keep || rx_verdict.drop))
    else $error("verdict longer than one cycle");
  chk_half_no_hold: assert property (
    !full_duplex [*3] |-> !tx_hold)
    else $error("hold in half duplex");
  chk_hold_cause: assert property (
    $rose(tx_hold) |-> $past(pause_rx))
    else $error("hold without pause");
  chk_bus_wait: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  chk_bus_ack: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer too long");
endmodule

bind mac_status_ctrl mac_status_ctrl_checker #(.PAUSE_QUANTUM(PAUSE_QUANTUM)) i_chk (
  .clk(clk), .srst(srst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .tx_report(tx_report), .tx_restart(tx_restart),
  .tx_halt(tx_halt), .tx_hold(tx_hold), .full_duplex(full_duplex), .pause_rx(pause_rx),
  .rx_frame(rx_frame), .rx_verdict(rx_verdict));

// ===== mac_status_ctrl_tb.sv
module mac_status_ctrl_tb
  import mac_status_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Bench signals
  // ----------------------------------------
  localparam logic [47:0] STA = 48'h0200_0000_0001;
  localparam logic [47:0] GRP = 48'h0100_0000_0000;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [5:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, tx_restart = 1'b0, tx_halt, tx_hold, pause_rx, full_duplex;
  logic rx_running, irq;
  logic [15:0] pause_quanta;
  tx_report_t tx_report;
  rx_frame_t rx_frame;
  rx_verdict_t rx_verdict;
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;

  // Clock
  always #2.5 clk = ~clk;

  mac_status_ctrl #(.PAUSE_QUANTUM(4)) i_dut (
    .clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .tx_report(tx_report), .tx_restart(tx_restart), .tx_halt(tx_halt), .tx_hold(tx_hold),
    .full_duplex(full_duplex), .pause_rx(pause_rx), .pause_quanta(pause_quanta),
    .rx_frame(rx_frame), .station_addr(STA), .rx_verdict(rx_verdict),
    .rx_running(rx_running), .irq(irq));

  mac_link_model i_link (
    .clk(clk), .tx_report(tx_report), .pause_rx(pause_rx), .pause_quanta(pause_quanta),
    .rx_frame(rx_frame), .full_duplex(full_duplex));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task wrap_up;
    if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    avs_read <= ~w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task rd(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, '0, q);
    chk($sformatf("reg %h", a), e, q);
  endtask

  task frame(input logic [15:0] c, input logic [47:0] da, input logic ce, hh, k);
    wr(6'h10, {16'h0, c});
    i_link.rx_start;
    i_link.rx_end(da, ce, hh);
    #1 chk("keep", k, rx_verdict.keep);
    chk("drop", !k, rx_verdict.drop);
    chk("strip", c[3], rx_verdict.strip_crc);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs;
    rd(6'h08, 32'h0);
    rd(6'h10, 32'h0);
    wr(6'h10, 32'hFFFF);
    rd(6'h10, 32'h06FD);
    wr(6'h10, 32'h0);
    rd(6'h3C, 32'h0);
  endtask

  task t_tx;
    wr(6'h1C, 32'h3);
    i_link.tx_end(1'b1, 1'b0, 1'b0, 6'h05);
    #1 chk("halt", 1, tx_halt);
    chk("irq", 1, irq);
    rd(6'h08, 32'h4005);
    rd(6'h20, 32'h2);
    wr(6'h08, 32'h0);
    rd(6'h08, 32'h4005);
    i_link.tx_end(1'b0, 1'b1, 1'b0, 6'h3F);
    rd(6'h08, 32'h203F);
    i_link.tx_end(1'b0, 1'b0, 1'b1, 6'h01);
    rd(6'h08, 32'h1001);
    chk("halt", 1, tx_halt);
    @(posedge clk) tx_restart <= 1'b1;
    @(posedge clk) tx_restart <= 1'b0;
    #1 chk("halt", 0, tx_halt);
    rd(6'h18, 32'h3);
    wr(6'h18, 32'hF);
    rd(6'h18, 32'h0);
    chk("irq", 0, irq);
  endtask

  task t_rx;
    frame(16'h0081, BCAST_ADDR, 1'b0, 1'b0, 1'b1);
    frame(16'h0001, BCAST_ADDR, 1'b0, 1'b0, 1'b0);
    frame(16'h0041, GRP, 1'b0, 1'b0, 1'b1);
    frame(16'h0041, BCAST_ADDR, 1'b0, 1'b0, 1'b1);
    frame(16'h0021, STA, 1'b0, 1'b0, 1'b1);
    frame(16'h0021, STA ^ 48'h1, 1'b0, 1'b0, 1'b0);
    frame(16'h0019, STA ^ 48'h1, 1'b0, 1'b0, 1'b1);
    frame(16'h0005, GRP, 1'b0, 1'b1, 1'b1);
    frame(16'h0005, GRP, 1'b0, 1'b0, 1'b0);
    frame(16'h0011, STA, 1'b1, 1'b0, 1'b0);
    frame(16'h0211, STA, 1'b1, 1'b0, 1'b1);
  endtask

  task t_stop;
    wr(6'h10, 32'h0011);
    i_link.rx_start;
    #1 chk("running", 1, rx_running);
    wr(6'h10, 32'h0010);
    i_link.rx_end(STA, 1'b0, 1'b0);
    #1 chk("keep", 1, rx_verdict.keep);
    repeat (2) @(posedge clk);
    #1 chk("running", 0, rx_running);
    i_link.rx_start;
    i_link.rx_end(STA, 1'b0, 1'b0);
    #1 chk("keep", 0, rx_verdict.keep | rx_verdict.drop);
  endtask

  task t_pause;
    wr(6'h10, 32'h0400);
    i_link.pause(1'b1, 16'h2);
    #1 chk("hold", 1, tx_hold);
    repeat (5) @(posedge clk);
    #1 chk("hold", 1, tx_hold);
    repeat (6) @(posedge clk);
    #1 chk("hold", 0, tx_hold);
    i_link.pause(1'b0, 16'h2);
    #1 chk("hold", 0, tx_hold);
    wr(6'h10, 32'h0);
    i_link.pause(1'b1, 16'h2);
    #1 chk("hold", 0, tx_hold);
  endtask

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      wrap_up;
    end
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    t_regs;
    t_tx;
    t_rx;
    t_stop;
    t_pause;
    wrap_up;
  end
endmodule

// ===== mac_status_pkg.sv
package mac_status_pkg;

  // ----------------------------------------
  // Register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [3:0] IDX_TRANSMIT_STATUS = 4'h2;
  localparam logic [3:0] IDX_RECEIVE_CONTROL = 4'h4;
  localparam logic [3:0] IDX_EVENT_STATUS = 4'h6;
  localparam logic [3:0] IDX_EVENT_MASK = 4'h7;
  localparam logic [3:0] IDX_LINK_STATE = 4'h8;

  // ----------------------------------------
  // Transmit status fields
  // ----------------------------------------
  localparam int TXS_UNDERRUN_BIT = 14;
  localparam int TXS_LATE_COL_BIT = 13;
  localparam int TXS_MAX_COL_BIT = 12;
  localparam int TXS_FID_LSB = 0;
  localparam int FID_W = 6;

  // ----------------------------------------
  // Receive control fields
  // ----------------------------------------
  localparam int RXC_PAUSE_BIT = 10;
  localparam int RXC_ERR_FRAME_BIT = 9;
  localparam int RXC_BCAST_BIT = 7;
  localparam int RXC_MCAST_BIT = 6;
  localparam int RXC_UCAST_BIT = 5;
  localparam int RXC_ALL_BIT = 4;
  localparam int RXC_STRIP_BIT = 3;
  localparam int RXC_HASH_BIT = 2;
  localparam int RXC_RUN_BIT = 0;
  localparam logic [15:0] RXC_WRITABLE = 16'h06FD;
  localparam logic [15:0] RXC_RESET = 16'h0000;
  localparam logic [15:0] TXS_RESET = 16'h0000;

  // ----------------------------------------
  // Event status / mask fields
  // ----------------------------------------
  localparam int EV_TX_DONE_BIT = 0;
  localparam int EV_TX_UNDERRUN_BIT = 1;
  localparam int EV_RX_KEPT_BIT = 2;
  localparam int EV_RX_DROPPED_BIT = 3;
  localparam int EV_W = 4;
  localparam logic [EV_W-1:0] EV_RESET = 4'h0;

  // Link state read bits
  localparam int LS_RUN_BIT = 0;
  localparam int LS_HALT_BIT = 1;
  localparam int LS_PAUSE_BIT = 2;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int PAUSE_QUANTUM_PS = 5120000; // 512 bit times at 100 Mb/s
  localparam int PAUSE_QUANTUM_CYC =
    (PAUSE_QUANTUM_PS / CLK_PERIOD_PS < 1) ? 1 : PAUSE_QUANTUM_PS / CLK_PERIOD_PS;

  localparam logic [47:0] BCAST_ADDR = 48'hFFFF_FFFF_FFFF;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic done;
    logic underrun;
    logic late_collision;
    logic max_collision;
    logic [FID_W-1:0] frame_id;
  } tx_report_t;

  typedef struct packed {
    logic start;
    logic done;
    logic crc_error;
    logic hash_hit;
    logic [47:0] dest_addr;
  } rx_frame_t;

  typedef struct packed {
    logic keep;
    logic drop;
    logic strip_crc;
  } rx_verdict_t;

  typedef enum logic [1:0] {
    RX_STOPPED = 2'b00,
    RX_IDLE = 2'b01,
    RX_BUSY = 2'b10
  } rx_state_t;

endpackage
